// >>> rtl/dls_pkg.sv
// Purpose: Shared constants and helpers for the dual-channel serial LVDS output link.
// Assumes: A 20 MHz core clock on both ends.
// Notes:   Lane codes follow the lane-select pin encoding.
package dls_pkg;
    // ------------------------------------------------------------
    // Word and lane layout
    // ------------------------------------------------------------
    localparam int          WORD_BITS   = 16;
    localparam int          MAX_LANES   = 4;
    localparam logic [1:0]  LANE_TWO    = 2'h0;
    localparam logic [1:0]  LANE_FOUR   = 2'h1;
    localparam logic [1:0]  LANE_ONE    = 2'h2;
    localparam logic [1:0]  LANE_UNUSED = 2'h3;
    // ------------------------------------------------------------
    // Driver current codes
    // ------------------------------------------------------------
    localparam logic [2:0]  CUR_3P5     = 3'h0;
    localparam logic [2:0]  CUR_4P0     = 3'h1;
    localparam logic [2:0]  CUR_4P5     = 3'h2;
    localparam logic [2:0]  CUR_3P0     = 3'h4;
    localparam logic [2:0]  CUR_2P5     = 3'h5;
    localparam logic [2:0]  CUR_2P1     = 3'h6;
    localparam logic [2:0]  CUR_1P75    = 3'h7;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          NAP_PERIOD_NS = 2000;
    localparam int          LOCK_TIME_NS  = 25000;
    localparam int          NAP_CYCLES    = NAP_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          LOCK_CYCLES   = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          BIT_CYCLES    = 4;
    localparam int          WAKE_FRAMES   = 100;
    localparam int          FIFO_DEPTH    = 16;

    // Number of active lanes for a lane code.
    function automatic logic [2:0] lane_count(input logic [1:0] mode);
        case (mode)
            LANE_FOUR: lane_count = 3'h4;
            LANE_ONE:  lane_count = 3'h1;
            default:   lane_count = 3'h2;
        endcase
    endfunction

    // Top bits of a word spread over the lanes, lane 0 carrying the MSB.
    function automatic logic [3:0] lane_bits(input logic [15:0] w, input logic [2:0] n);
        lane_bits = {w[12] & (n == 3'h4), w[13] & (n == 3'h4), w[14] & (n != 3'h1), w[15]};
    endfunction

    // Append the lane bits of one edge below an accumulated word.
    function automatic logic [15:0] lane_merge(input logic [15:0] acc, input logic [3:0] l,
                                               input logic [2:0] n);
        case (n)
            3'h4:    lane_merge = {acc[11:0], l[0], l[1], l[2], l[3]};
            3'h1:    lane_merge = {acc[14:0], l[0]};
            default: lane_merge = {acc[13:0], l[0], l[1]};
        endcase
    endfunction
endpackage

// >>> rtl/dls_link_if.sv
// Purpose: Serial LVDS link between the converter output end and the receiver.
// Assumes: Each differential pair is modelled as one logic level.
// Notes:   The receiver samples every signal with its own clock.
`timescale 1ns/1ps
interface dls_link_if;
    logic [3:0] lane_ch1;
    logic [3:0] lane_ch2;
    logic       forwarded_bit_clock;
    logic       frame_marker;
    logic       drive_en;
    modport dev (
        output lane_ch1,
        output lane_ch2,
        output forwarded_bit_clock,
        output frame_marker,
        output drive_en
    );
    modport rcv (
        input lane_ch1,
        input lane_ch2,
        input forwarded_bit_clock,
        input frame_marker,
        input drive_en
    );
endinterface

// >>> rtl/dls_fifo.sv
// Purpose: Sample buffer with valid and ready on both sides.
// Assumes: Single clock domain.
// Notes:   Depth must be a power of two.
`timescale 1ns/1ps
module dls_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
        $error("dls_fifo: DEPTH must be a power of two of at least 2");
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      rd_reg;
    logic             push;
    logic             pop;
    assign in_ready  = (wr_reg - rd_reg) != (AW + 1)'(DEPTH);
    assign out_valid = wr_reg != rd_reg;
    assign out_data  = mem_reg[rd_reg[AW-1:0]];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    always_ff @(posedge clock) begin
        if (push)
            mem_reg[wr_reg[AW-1:0]] <= in_data;
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push)
                wr_reg <= wr_reg + 1'b1;
            if (pop)
                rd_reg <= rd_reg + 1'b1;
        end
    end
endmodule

// >>> rtl/dls_tx.sv
// Purpose: Converter output end: formats both channels and serializes them over LVDS lanes.
// Assumes: Samples arrive on the core clock; straps and the sample clock are asynchronous pins.
// Notes:   Bit clock is divided from the core clock; data changes half a bit before each edge.
`timescale 1ns/1ps
module dls_tx
    import dls_pkg::*;
#(
    parameter int DEPTH    = FIFO_DEPTH,
    parameter int BIT_DIV  = BIT_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        sample_valid,
    input  wire logic [15:0] sample_ch1,
    input  wire logic [15:0] sample_ch2,
    output logic             sample_ready,
    input  wire logic        sample_clock_pos,
    input  wire logic        sample_clock_neg,
    input  wire logic        programming_style_select,
    input  wire logic [1:0]  lane_select_pins,
    input  wire logic        current_select_pin,
    input  wire logic [1:0]  cfg_lane_mode,
    input  wire logic        cfg_dcs_enable,
    input  wire logic [2:0]  cfg_current_code,
    input  wire logic        cfg_term_enable,
    input  wire logic        cfg_twos_complement,
    input  wire logic        cfg_randomize,
    input  wire logic        cfg_test_enable,
    input  wire logic [15:0] cfg_test_ch1,
    input  wire logic [15:0] cfg_test_ch2,
    input  wire logic        cfg_output_disable,
    output logic             nap_active,
    output logic             pll_locked,
    output logic [1:0]       lane_mode_active,
    output logic [2:0]       drive_current_code,
    output logic             drive_current_double,
    output logic             term_active,
    output logic             dcs_active,
    output logic             cfg_conflict,
    dls_link_if.dev          link
);
    if (BIT_DIV < 2 || BIT_DIV % 2 != 0)
        $error("dls_tx: BIT_DIV must be even and at least 2");

    typedef enum logic [2:0] {
        DLS_NAP  = 3'b001,
        DLS_LOCK = 3'b010,
        DLS_RUN  = 3'b100
    } dls_state_e;

    // ------------------------------------------------------------
    // Pin synchronizers
    // ------------------------------------------------------------
    logic [5:0] pin_s1_reg;
    logic [5:0] pin_s2_reg;
    logic       enc_prev_reg;
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_s1_reg   <= 6'h00;
            pin_s2_reg   <= 6'h00;
            enc_prev_reg <= 1'b0;
        end else begin
            pin_s1_reg   <= {sample_clock_neg, sample_clock_pos, programming_style_select,
                             lane_select_pins, current_select_pin};
            pin_s2_reg   <= pin_s1_reg;
            enc_prev_reg <= pin_s2_reg[4] & ~pin_s2_reg[5];
        end
    end
    logic       parallel;
    logic [1:0] pin_lanes;
    logic       pin_csel;
    logic       enc_level;
    logic       enc_rise;
    assign parallel  = pin_s2_reg[3];
    assign pin_lanes = pin_s2_reg[2:1];
    assign pin_csel  = pin_s2_reg[0];
    assign enc_level = pin_s2_reg[4] & ~pin_s2_reg[5];
    assign enc_rise  = enc_level & ~enc_prev_reg;

    // ------------------------------------------------------------
    // Effective configuration
    // ------------------------------------------------------------
    logic       dcs_next;
    logic [1:0] lane_req;
    logic       conflict_next;
    assign dcs_next      = parallel | cfg_dcs_enable;
    assign lane_req      = parallel ? pin_lanes : cfg_lane_mode;
    assign conflict_next = (lane_req == LANE_FOUR) & ~dcs_next;
    always_ff @(posedge clock) begin
        if (rst) begin
            dcs_active           <= 1'b1;
            lane_mode_active     <= LANE_TWO;
            cfg_conflict         <= 1'b0;
            drive_current_code   <= CUR_3P5;
            term_active          <= 1'b0;
            drive_current_double <= 1'b0;
        end else begin
            dcs_active   <= dcs_next;
            cfg_conflict <= conflict_next;
            if (conflict_next || lane_req == LANE_UNUSED)
                lane_mode_active <= LANE_TWO;
            else
                lane_mode_active <= lane_req;
            if (parallel)
                drive_current_code <= pin_csel ? CUR_1P75 : CUR_3P5;
            else
                drive_current_code <= cfg_current_code;
            term_active          <= ~parallel & cfg_term_enable;
            drive_current_double <= ~parallel & cfg_term_enable;
        end
    end

    // ------------------------------------------------------------
    // Sample clock watch and lock timing
    // ------------------------------------------------------------
    dls_state_e state_reg;
    logic [15:0] count_reg;
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= DLS_NAP;
            count_reg <= 16'h0000;
        end else begin
            case (state_reg)
                DLS_NAP: begin
                    count_reg <= 16'h0000;
                    if (enc_rise)
                        state_reg <= DLS_LOCK;
                end
                DLS_LOCK: begin
                    if (count_reg == 16'(LOCK_CYCLES - 1)) begin
                        state_reg <= DLS_RUN;
                        count_reg <= 16'h0000;
                    end else
                        count_reg <= count_reg + 16'h0001;
                end
                DLS_RUN: begin
                    if (enc_rise)
                        count_reg <= 16'h0000;
                    else if (count_reg == 16'(NAP_CYCLES))
                        state_reg <= DLS_NAP;
                    else
                        count_reg <= count_reg + 16'h0001;
                end
                default: state_reg <= DLS_NAP;
            endcase
        end
    end
    logic running;
    assign running = state_reg == DLS_RUN;
    always_ff @(posedge clock) begin
        if (rst) begin
            nap_active <= 1'b1;
            pll_locked <= 1'b0;
        end else begin
            nap_active <= state_reg == DLS_NAP;
            pll_locked <= running;
        end
    end

    // ------------------------------------------------------------
    // Sample buffer and formatting
    // ------------------------------------------------------------
    logic [31:0] fifo_data;
    logic        fifo_valid;
    logic        word_start;
    logic [31:0] hold_reg;
    dls_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (sample_valid),
        .in_data   ({sample_ch1, sample_ch2}),
        .in_ready  (sample_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (word_start)
    );
    logic [31:0] next_raw;
    logic [2:0]  fmt_opt;
    assign next_raw = fifo_valid ? fifo_data : hold_reg;
    assign fmt_opt  = parallel ? 3'h0 : {cfg_test_enable, cfg_randomize, cfg_twos_complement};

    function automatic logic [15:0] fmt(input logic [15:0] raw, pat, input logic [2:0] opt);
        logic [15:0] w;
        w = raw;
        if (opt[0])
            w[15] = ~w[15];
        if (opt[1])
            w[15:1] = w[15:1] ^ {15{w[0]}};
        fmt = opt[2] ? pat : w;
    endfunction

    // ------------------------------------------------------------
    // Serializer
    // ------------------------------------------------------------
    logic [7:0]  phase_reg;
    logic [3:0]  bit_reg;
    logic [2:0]  nl_reg;
    logic [15:0] sh1_reg;
    logic [15:0] sh2_reg;
    logic [2:0]  nl_use;
    logic [15:0] w1;
    logic [15:0] w2;
    assign word_start = running & (phase_reg == 8'h00) & (bit_reg == 4'h0);
    assign nl_use     = (bit_reg == 4'h0) ? lane_count(lane_mode_active) : nl_reg;
    assign w1         = (bit_reg == 4'h0) ? fmt(next_raw[31:16], cfg_test_ch1, fmt_opt) : sh1_reg;
    assign w2         = (bit_reg == 4'h0) ? fmt(next_raw[15:0], cfg_test_ch2, fmt_opt) : sh2_reg;
    always_ff @(posedge clock) begin
        if (rst)
            hold_reg <= 32'h80008000;
        else if (word_start && fifo_valid)
            hold_reg <= fifo_data;
    end
    always_ff @(posedge clock) begin
        if (rst || !running) begin
            phase_reg                <= 8'h00;
            bit_reg                  <= 4'h0;
            nl_reg                   <= 3'h2;
            sh1_reg                  <= 16'h0000;
            sh2_reg                  <= 16'h0000;
            link.lane_ch1            <= 4'h0;
            link.lane_ch2            <= 4'h0;
            link.frame_marker        <= 1'b0;
            link.forwarded_bit_clock <= 1'b0;
        end else begin
            phase_reg <= (phase_reg == 8'(BIT_DIV - 1)) ? 8'h00 : phase_reg + 8'h01;
            if (phase_reg == 8'h00) begin
                nl_reg        <= nl_use;
                link.lane_ch1 <= lane_bits(w1, nl_use);
                link.lane_ch2 <= lane_bits(w2, nl_use);
                sh1_reg       <= w1 << nl_use;
                sh2_reg       <= w2 << nl_use;
                link.frame_marker <= bit_reg < 4'(8 / nl_use);
                if (bit_reg == 4'(16 / nl_use - 1))
                    bit_reg <= 4'h0;
                else
                    bit_reg <= bit_reg + 4'h1;
            end
            if (phase_reg == 8'(BIT_DIV / 2))
                link.forwarded_bit_clock <= ~link.forwarded_bit_clock;
        end
    end
    always_ff @(posedge clock) begin
        if (rst)
            link.drive_en <= 1'b0;
        else
            link.drive_en <= running & ~(~parallel & cfg_output_disable);
    end
endmodule

// >>> rtl/dls_rx.sv
// Purpose: Receiver end: samples the LVDS lanes on both bit clock edges and rebuilds words.
// Assumes: Link signals are asynchronous to the core clock and are synchronized here.
// Notes:   Data must be stable for at least one core clock before each bit clock edge.
`timescale 1ns/1ps
module dls_rx
    import dls_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [1:0]  rx_lane_mode,
    input  wire logic        rx_derandomize,
    output logic             rx_valid,
    output logic [15:0]      rx_ch1,
    output logic [15:0]      rx_ch2,
    output logic             rx_awake,
    dls_link_if.rcv          link
);
    // ------------------------------------------------------------
    // Link synchronizers
    // ------------------------------------------------------------
    logic [10:0] s1_reg;
    logic [10:0] s2_reg;
    logic        clk_prev_reg;
    always_ff @(posedge clock) begin
        if (rst) begin
            s1_reg       <= 11'h000;
            s2_reg       <= 11'h000;
            clk_prev_reg <= 1'b0;
        end else begin
            s1_reg       <= {link.drive_en, link.forwarded_bit_clock, link.frame_marker,
                             link.lane_ch1, link.lane_ch2};
            s2_reg       <= s1_reg;
            clk_prev_reg <= s2_reg[9];
        end
    end
    logic edge_seen;
    assign edge_seen = s2_reg[9] ^ clk_prev_reg;

    // ------------------------------------------------------------
    // Word assembly
    // ------------------------------------------------------------
    logic [2:0]  nl;
    logic        fr_prev_reg;
    logic [15:0] acc1_reg;
    logic [15:0] acc2_reg;
    logic [4:0]  cnt_reg;
    logic [15:0] m1;
    logic [15:0] m2;
    logic [4:0]  cnt_next;
    logic        start;
    assign nl       = lane_count(rx_lane_mode);
    assign start    = s2_reg[8] & ~fr_prev_reg;
    assign m1       = lane_merge(start ? 16'h0000 : acc1_reg, s2_reg[7:4], nl);
    assign m2       = lane_merge(start ? 16'h0000 : acc2_reg, s2_reg[3:0], nl);
    assign cnt_next = (start ? 5'h00 : cnt_reg) + {2'b00, nl};

    function automatic logic [15:0] derand(input logic [15:0] w);
        derand = rx_derandomize ? {w[15:1] ^ {15{w[0]}}, w[0]} : w;
    endfunction

    logic [7:0] wake_reg;
    always_ff @(posedge clock) begin
        if (rst) begin
            fr_prev_reg <= 1'b0;
            acc1_reg    <= 16'h0000;
            acc2_reg    <= 16'h0000;
            cnt_reg     <= 5'h10;
            rx_valid    <= 1'b0;
            rx_ch1      <= 16'h0000;
            rx_ch2      <= 16'h0000;
        end else begin
            rx_valid <= 1'b0;
            if (edge_seen) begin
                fr_prev_reg <= s2_reg[8];
                acc1_reg    <= m1;
                acc2_reg    <= m2;
                cnt_reg     <= cnt_next;
                if (cnt_next == 5'h10 && (start || cnt_reg != 5'h10)) begin
                    rx_valid <= rx_awake;
                    rx_ch1   <= derand(m1);
                    rx_ch2   <= derand(m2);
                end
            end
        end
    end
    always_ff @(posedge clock) begin
        if (rst || !s2_reg[10]) begin
            wake_reg <= 8'h00;
            rx_awake <= 1'b0;
        end else begin
            if (edge_seen && start && wake_reg != 8'(WAKE_FRAMES))
                wake_reg <= wake_reg + 8'h01;
            rx_awake <= wake_reg == 8'(WAKE_FRAMES);
        end
    end
endmodule

// >>> sim/dls_link_checker.sv
// Purpose: Link-level assertions for the serial LVDS output link.
// Assumes: Bit time of four core clocks.
// Notes:   Checks rest while the drivers are off.
`timescale 1ns/1ps
module dls_link_checker (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic [3:0] lane_ch1,
    input wire logic [3:0] lane_ch2,
    input wire logic       forwarded_bit_clock,
    input wire logic       frame_marker,
    input wire logic       drive_en
);
    // ----------------------------------------
    // Link timing
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (rst || !drive_en);
    chk_clock_period: assert property (
        $changed(forwarded_bit_clock) |=> $stable(forwarded_bit_clock) [*3])
        else $error("bit clock toggled early");
    chk_ch1_bit_hold: assert property ($changed(lane_ch1) |=> $stable(lane_ch1) [*3])
        else $error("ch1 bit shorter than a bit time");
    chk_ch2_bit_hold: assert property ($changed(lane_ch2) |=> $stable(lane_ch2) [*3])
        else $error("ch2 bit shorter than a bit time");
    chk_data_mid_clock: assert property ($changed(forwarded_bit_clock) |->
        $stable(lane_ch1) && $stable(lane_ch2) && $stable(frame_marker))
        else $error("data moved on a clock edge");
    chk_ch1_clock_follow: assert property ($changed(lane_ch1) |-> ##2
        $changed(forwarded_bit_clock)) else $error("no clock edge mid bit");
    chk_frame_clock_follow: assert property ($rose(frame_marker) |-> ##2
        $changed(forwarded_bit_clock)) else $error("frame not on a bit start");
    chk_frame_high_min: assert property ($rose(frame_marker) |=> frame_marker [*7])
        else $error("frame high too short");
    chk_frame_low_min: assert property ($fell(frame_marker) |=> !frame_marker [*7])
        else $error("frame low too short");
    cover property ($rose(frame_marker));
    cover property ($fell(frame_marker));
    cover property ($changed(lane_ch2));
endmodule

// >>> sim/test_dual_adc_serial_lvds_output.sv
// Purpose: Self-checking bench joining both link ends.
// Assumes: Single-ended 200 ns encode clock.
// Notes:   Expected words follow the output format rules.
`timescale 1ns/1ps
module test_dual_adc_serial_lvds_output;
    import dls_pkg::*;
    // ----------------------------------------
    // Stimulus and wiring
    // ----------------------------------------
    logic        clock = 1'b0, rst = 1'b1, enc_on = 1'b0, enc = 1'b0, sv = 1'b0, pss = 1'b0;
    logic        csp = 1'b0, dcs = 1'b1, term = 1'b0, twos = 1'b0, rnd = 1'b0, ten = 1'b0;
    logic        dis = 1'b0, derand = 1'b0, rdy, nap, lock, dbl, tact, dact, conf, rxv, awake;
    logic [1:0]  lsp = 2'h0, lm = LANE_TWO, rxm = LANE_TWO, lma;
    logic [2:0]  cur = CUR_3P5, dcc;
    logic [15:0] s1 = 16'h0, s2 = 16'h0, t1 = 16'h0, t2 = 16'h0, r1, r2;
    int          n_errors = 0, total_checks = 0, cyc = 0;
    dls_link_if link ();
    dls_tx dls_tx_inst (.clock(clock), .rst(rst), .sample_valid(sv), .sample_ch1(s1),
        .sample_ch2(s2), .sample_ready(rdy), .sample_clock_pos(enc), .sample_clock_neg(1'b0),
        .programming_style_select(pss), .lane_select_pins(lsp), .current_select_pin(csp),
        .cfg_lane_mode(lm), .cfg_dcs_enable(dcs), .cfg_current_code(cur),
        .cfg_term_enable(term), .cfg_twos_complement(twos), .cfg_randomize(rnd),
        .cfg_test_enable(ten), .cfg_test_ch1(t1), .cfg_test_ch2(t2), .cfg_output_disable(dis),
        .nap_active(nap), .pll_locked(lock), .lane_mode_active(lma), .drive_current_code(dcc),
        .drive_current_double(dbl), .term_active(tact), .dcs_active(dact),
        .cfg_conflict(conf), .link(link.dev));
    dls_rx dls_rx_inst (.clock(clock), .rst(rst), .rx_lane_mode(rxm), .rx_derandomize(derand),
        .rx_valid(rxv), .rx_ch1(r1), .rx_ch2(r2), .rx_awake(awake), .link(link.rcv));
    dls_link_checker dls_link_checker_inst (.clock(clock), .rst(rst),
        .lane_ch1(link.lane_ch1), .lane_ch2(link.lane_ch2),
        .forwarded_bit_clock(link.forwarded_bit_clock), .frame_marker(link.frame_marker),
        .drive_en(link.drive_en));
    always #25 clock = ~clock;
    always #100 if (enc_on) enc = ~enc;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            test_done();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [15:0] a, b, ea, eb);
        int n;
        s1 <= a;
        s2 <= b;
        sv <= 1'b1;
        tick(1);
        for (n = 0; n < 3000 && rdy !== 1'b1; n++) tick(1);
        sv <= 1'b0;
        for (n = 0; n < 3000 && !(rxv === 1'b1 && r1 === ea && r2 === eb); n++) tick(1);
        check(r1, ea);
        check(r2, eb);
    endtask
    task automatic restart(input logic [1:0] m);
        int n;
        dis <= 1'b1;
        lm <= m;
        rxm <= m;
        tick(4);
        check(link.drive_en, 1'b0);
        dis <= 1'b0;
        for (n = 0; n < 8000 && awake !== 1'b1; n++) tick(1);
        check(awake, 1'b1);
        check(lma, m);
    endtask
    task automatic t_lock_lanes();
        int n;
        logic [1:0] m [3] = '{LANE_TWO, LANE_FOUR, LANE_ONE};
        tick(400);
        check(lock, 1'b0);
        for (n = 0; n < 300 && lock !== 1'b1; n++) tick(1);
        check(lock, 1'b1);
        foreach (m[i]) begin
            restart(m[i]);
            send(16'h8001 + 16'(i), 16'h7ffe, 16'h8001 + 16'(i), 16'h7ffe);
        end
        send(16'hffff, 16'h0000, 16'hffff, 16'h0000);
        $display("lock and lane test done");
    endtask
    task automatic t_format();
        twos <= 1'b1;
        send(16'h1234, 16'hfedc, 16'h9234, 16'h7edc);
        twos <= 1'b0;
        rnd <= 1'b1;
        send(16'h00f1, 16'h1230, 16'hff0f, 16'h1230);
        derand <= 1'b1;
        send(16'h5a5b, 16'h0003, 16'h5a5b, 16'h0003);
        ten <= 1'b1;
        twos <= 1'b1;
        derand <= 1'b0;
        t1 <= 16'ha5a5;
        t2 <= 16'h0001;
        send(16'h1111, 16'h2222, 16'ha5a5, 16'h0001);
        {ten, twos, rnd} <= 3'h0;
        $display("format test done");
    endtask
    task automatic t_config();
        logic [2:0] c [7] = '{CUR_1P75, CUR_2P1, CUR_2P5, CUR_3P0, CUR_4P0, CUR_4P5, CUR_3P5};
        check(dcc, CUR_3P5);
        dcs <= 1'b0;
        lm <= LANE_FOUR;
        tick(80);
        check({conf, dact, lma}, {2'h2, LANE_TWO});
        foreach (c[i]) begin
            cur <= c[i];
            tick(4);
            check(dcc, c[i]);
        end
        term <= 1'b1;
        tick(4);
        check({dbl, tact}, 2'h3);
        {pss, csp, lsp} <= {2'h3, LANE_ONE};
        tick(80);
        check({dcc, dbl, tact, dact, lma}, {CUR_1P75, 3'h1, LANE_ONE});
        lsp <= LANE_UNUSED;
        tick(80);
        check(lma, LANE_TWO);
        {pss, csp, dcs, term} <= 4'h2;
        $display("config test done");
    endtask
    task automatic t_fill_nap();
        logic full = 1'b0;
        restart(LANE_TWO);
        s1 <= 16'h0101;
        sv <= 1'b1;
        repeat (24) begin
            tick(1);
            if (rdy === 1'b0) full = 1'b1;
        end
        sv <= 1'b0;
        check(full, 1'b1);
        tick(1);
        send(16'hbeef, 16'h0000, 16'hbeef, 16'h0000);
        enc_on <= 1'b0;
        tick(100);
        check({nap, lock, link.drive_en}, 3'h4);
        $display("fill and nap test done");
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        tick(5);
        rst <= 1'b0;
        enc_on <= 1'b1;
        t_lock_lanes();
        t_format();
        t_config();
        t_fill_nap();
        test_done();
    end
endmodule
